// file: logic/i2crp_pkg.sv
// Functional notes
// [RULE_01] works at 100 kHz and 400 kHz
// [RULE_02] spikes under 50 ns are filtered out
// [RULE_03] slave only, serial clock never driven
// [RULE_04] respond only on own 7-bit address
// [RULE_05] own address picked from seven values
// [RULE_06] start/stop are data edges, clock high
// [RULE_07] master alone makes start and stop
// [RULE_08] data changes only while clock low
// [RULE_09] eight bits, msb first, then ack
// [RULE_10] ack pulls data low on ninth pulse
// [RULE_11] nack leaves data high on ninth pulse
// [RULE_12] address byte: address then direction bit
// [RULE_13] start rearms receiver; mismatch stays idle
// [RULE_14] write: two register address bytes, high first
// [RULE_15] following write bytes stored, unlimited count
// [RULE_16] address-only write sets current address
// [RULE_17] read sends bytes from current address
// [RULE_18] combined write-address, repeated start, read
// [RULE_19] master nack ends read, device releases
// [RULE_20] master stops after final acknowledge slot
// [RULE_21] repeated start begins a new transfer
// [RULE_22] start/stop discards partial byte unwritten
// [RULE_23] denied register reads zero, write ignored
// [RULE_24] address advances after each data byte
package i2crp_pkg;
  // rates and filter time
  localparam int STD_MODE_KHZ = 100;
  localparam int FAST_MODE_KHZ = 400;
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_CLK_MHZ = 166;
  localparam int GLITCH_NS = 50;
  // least time rounds up to whole link clock cycles
  localparam int GLITCH_CYC = (GLITCH_NS * LINK_CLK_MHZ + 999) / 1000;
  // frame layout
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam int ADDR_COUNT = 7;
  localparam logic [2:0] SEL_MAX = 3'h6;
  localparam logic [6:0] ADDR_BASE_DEF = 7'h48;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // reset values
  localparam logic [15:0] CUR_ADDR_RST = 16'h0000;
  localparam logic [7:0] READ_DENIED = 8'h00;

  // byte position inside a transfer
  typedef enum logic [1:0] {
    I2CRP_PH_DEV = 2'b00,
    I2CRP_PH_AHI = 2'b01,
    I2CRP_PH_ALO = 2'b11,
    I2CRP_PH_DAT = 2'b10
  } i2crp_phase_t;

  // bit-level receiver/transmitter states
  typedef enum logic [2:0] {
    I2CRP_IDLE = 3'b000,
    I2CRP_RX = 3'b001,
    I2CRP_ACK = 3'b011,
    I2CRP_TX = 3'b010,
    I2CRP_RACK = 3'b110
  } i2crp_state_t;
endpackage : i2crp_pkg

// file: logic/i2crp_filter.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_filter
  import i2crp_pkg::*;
#(
  parameter int CYC = GLITCH_CYC
) (
  input wire logic clk, // link clock
  input wire logic rst, // async, active high
  input wire logic pin, // raw bus line
  output logic level // filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic out;
  } i2crp_flt_t;

  i2crp_flt_t s;
  i2crp_flt_t next_s;

  // a new level must stand a full glitch time before it is accepted
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    if (s.s2 == s.out) begin
      next_s.cnt = 8'h00; // spike over: restart the count [RULE_02]
    end else if (s.cnt >= 8'(CYC - 1)) begin
      next_s.out = s.s2;
      next_s.cnt = 8'h00;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  // lines idle high, so the filter resets high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, out: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.out;
endmodule : i2crp_filter
`default_nettype wire

// file: logic/i2crp_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_bridge
  import i2crp_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // async, active high
  input wire logic req_tgl, // request toggle, link domain
  input wire logic req_we, // request is a write
  input wire logic [15:0] req_addr, // held with the toggle
  input wire logic [7:0] req_wdata, // held with the toggle
  output logic ack_tgl, // answer toggle to link domain
  output logic [7:0] rdata, // held with the answer toggle
  output logic [15:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // register write data
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // data for reg_addr
  input wire logic reg_deny // access to reg_addr refused
);
  typedef struct packed {
    logic r1;
    logic r2;
    logic seen;
    logic pend;
    logic we;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] rdata;
    logic ack_tgl;
  } i2crp_brg_t;

  i2crp_brg_t s;
  i2crp_brg_t next_s;

  // address first, answer one cycle later once the map has settled
  always_comb begin
    next_s = s;
    next_s.r1 = req_tgl;
    next_s.r2 = s.r1;
    next_s.reg_wr = 1'b0;
    next_s.reg_rd = 1'b0;
    if (s.pend) begin
      next_s.pend = 1'b0;
      next_s.ack_tgl = ~s.ack_tgl;
      if (s.we) begin
        next_s.reg_wr = ~reg_deny; // refused writes dropped [RULE_23]
      end else begin
        next_s.reg_rd = 1'b1;
        next_s.rdata = reg_deny ? READ_DENIED : reg_rdata; // [RULE_23]
      end
    end else if (s.r2 != s.seen) begin
      // request fields were held stable since the toggle moved
      next_s.seen = s.r2;
      next_s.pend = 1'b1;
      next_s.we = req_we;
      next_s.reg_addr = req_addr;
      next_s.reg_wdata = req_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ack_tgl = s.ack_tgl;
  assign rdata = s.rdata;
  assign reg_addr = s.reg_addr;
  assign reg_wdata = s.reg_wdata;
  assign reg_wr = s.reg_wr;
  assign reg_rd = s.reg_rd;
endmodule : i2crp_bridge
`default_nettype wire

// file: logic/i2crp_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_top
  import i2crp_pkg::*;
#(
  parameter logic [6:0] ADDR_BASE = ADDR_BASE_DEF // arbitrary default
) (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic link_clk, // link-side sampling clock
  input wire logic scl_i, // serial clock line level
  input wire logic sda_i, // serial data line level
  output logic sda_o, // data line drive value
  output logic sda_oe, // data line pulled low when high
  input wire logic [2:0] addr_sel, // own address strap
  output logic [15:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // register write data
  output logic reg_wr, // register write strobe
  output logic reg_rd, // register read strobe
  input wire logic [7:0] reg_rdata, // data at reg_addr
  input wire logic reg_deny, // register refused or absent
  output logic link_busy // addressed transfer in progress
);
  // the serial clock is only ever sampled; no output exists for it
  // so the device cannot stretch or drive it [RULE_03] [RULE_07]

  typedef struct packed {
    i2crp_state_t state;
    i2crp_phase_t phase;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic ackd;
    logic sda_oe;
    logic [15:0] cur_addr;
    logic [7:0] addr_hi;
    logic [6:0] my_addr;
    logic [2:0] sel1;
    logic [2:0] sel2;
    logic scl_p;
    logic sda_p;
    logic req_tgl;
    logic req_we;
    logic [15:0] req_addr;
    logic [7:0] req_wdata;
    logic ack1;
    logic ack2;
    logic ack_seen;
    logic [7:0] rd_byte;
    logic busy;
  } i2crp_link_t;

  i2crp_link_t s;
  i2crp_link_t next_s;

  logic link_rst;
  logic [1:0] rst_pipe;
  logic scl_f;
  logic sda_f;
  logic brg_ack_tgl;
  logic [7:0] brg_rdata;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // reset enters the link domain at once but leaves it on a link edge
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pipe <= 2'b11;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b0};
    end
  end
  assign link_rst = rst_pipe[1];

  // both lines pass a synchroniser and spike filter before use
  i2crp_filter #(
    .CYC(GLITCH_CYC)
  ) u_scl_flt (
    .clk(link_clk),
    .rst(link_rst),
    .pin(scl_i),
    .level(scl_f)
  );

  i2crp_filter #(
    .CYC(GLITCH_CYC)
  ) u_sda_flt (
    .clk(link_clk),
    .rst(link_rst),
    .pin(sda_i),
    .level(sda_f)
  );

  // register accesses run on the system clock behind a toggle handshake
  i2crp_bridge u_bridge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .req_tgl(s.req_tgl),
    .req_we(s.req_we),
    .req_addr(s.req_addr),
    .req_wdata(s.req_wdata),
    .ack_tgl(brg_ack_tgl),
    .rdata(brg_rdata),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_deny(reg_deny)
  );

  // own address: base plus strap, clamped to the seven legal values
  function automatic logic [6:0] own_addr(input logic [2:0] sel);
    logic [2:0] k;
    k = (sel > SEL_MAX) ? SEL_MAX : sel;
    own_addr = ADDR_BASE + {4'h0, k}; // [RULE_05]
  endfunction : own_addr

  // bus events from the filtered lines, data edges while clock high
  always_comb begin
    scl_rise = scl_f & ~s.scl_p;
    scl_fall = ~scl_f & s.scl_p;
    start_seen = scl_f & s.scl_p & s.sda_p & ~sda_f; // [RULE_06]
    stop_seen = scl_f & s.scl_p & ~s.sda_p & sda_f; // [RULE_06]
  end

  // how a transfer moves through the engine:
  //  idle - waits for a start; strap may be re-read here
  //  rx   - shifts eight bits in on filtered clock rises
  //  ack  - pulls data low from the fall after bit eight
  //         until the fall after the ninth pulse
  //  tx   - puts one bit out per falling clock edge
  //  rack - line released; samples the master's answer
  // byte phases inside a transfer:
  //  dev  - address byte, decides match and direction
  //  ahi  - register address, high half
  //  alo  - register address, low half; sets current address
  //  dat  - data bytes, one register write each
  // bus view of a write: S, address+W, hi, lo, data..., P
  // bus view of a read: S, address+R, data..., nack, P
  // a combined read is the first three bytes of a write, then a
  // repeated start and a read; both halves run through here
  // read data are fetched ahead of need: at the address byte end
  // and on each master ack, so a full clock high time is spent
  // crossing into the system domain and back
  // the fetch never moves the current address; only a byte really
  // sent or written does, so a nack'd read leaves it one past the
  // last byte the master saw
  // start and stop win over every state, so a cut frame always
  // ends cleanly even mid-byte; nothing partial reaches the map
  // limitation: a master with a high time shorter than the
  // filter delay plus fetch time could see stale read data
  // trade-off: the spike filter costs about a dozen link clocks of
  // latency on every edge, well inside the fast-mode low time
  // edge detect uses the previous filtered levels, which reset
  // high to match the idle bus, so no false start follows reset
  // denied writes are still acknowledged on the bus; the map
  // side drops them
  // the link state is one struct so every field shares one
  // reset and one clock; the system side never reads it except
  // through the request fields, which stand still while the
  // toggle is in flight
  // the acknowledge toggle passes two flops before its edge is
  // used; read data are held by the bridge until the next
  // request, so they are stable when taken
  // counter use: cnt counts bits in rx from zero to eight; in tx
  // it starts at one because the first bit leaves with the ack
  // end fall, and reaching eight frees the line for the master
  // the address strap passes two flops and is only taken while
  // idle, so a strap change mid-transfer cannot split a frame
  // an unmatched address leaves the engine idle: no ack, no drive,
  // no register traffic until the next start
  // protocol engine; the drive only moves on falling clock edges
  always_comb begin
    next_s = s;
    next_s.scl_p = scl_f;
    next_s.sda_p = sda_f;
    next_s.sel1 = addr_sel;
    next_s.sel2 = s.sel1;
    next_s.ack1 = brg_ack_tgl;
    next_s.ack2 = s.ack1;
    // read answer: data bus was held steady before the toggle moved
    if (s.ack2 != s.ack_seen) begin
      next_s.ack_seen = s.ack2;
      next_s.rd_byte = brg_rdata;
    end
    // strap only taken while no transfer could be disturbed
    if (s.state == I2CRP_IDLE) begin
      next_s.my_addr = own_addr(s.sel2);
    end
    if (start_seen) begin
      // start or repeated start rearms for an address byte and drops
      // any half byte without a register write [RULE_13] [RULE_21]
      next_s.state = I2CRP_RX; // [RULE_22]
      next_s.phase = I2CRP_PH_DEV;
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
      next_s.busy = 1'b0;
    end else if (stop_seen) begin
      // stop anywhere also discards a partial byte [RULE_22] [RULE_20]
      next_s.state = I2CRP_IDLE;
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
      next_s.busy = 1'b0;
    end else begin
      unique case (s.state)
        I2CRP_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        I2CRP_RX: begin
          // sample on the rising edge, msb first [RULE_08] [RULE_09]
          if (scl_rise && s.cnt < BIT_LAST) begin
            next_s.sh = {s.sh[6:0], sda_f};
            next_s.cnt = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == BIT_LAST) begin
            next_s.cnt = 4'h0;
            next_s.state = I2CRP_ACK;
            next_s.sda_oe = 1'b1; // ack low for ninth pulse [RULE_10]
            unique case (s.phase)
              I2CRP_PH_DEV: begin
                // address byte: seven address bits then direction
                if (s.sh[7:1] == s.my_addr) begin // [RULE_04] [RULE_12]
                  next_s.rw = s.sh[0];
                  next_s.busy = 1'b1;
                  next_s.phase = I2CRP_PH_AHI;
                  if (s.sh[0] == DIR_READ) begin
                    // fetch now so the byte is ready at ack end [RULE_17]
                    next_s.req_tgl = ~s.req_tgl;
                    next_s.req_we = 1'b0;
                    next_s.req_addr = s.cur_addr; // [RULE_18]
                  end
                end else begin
                  // not ours: no ack, bus left alone [RULE_13] [RULE_11]
                  next_s.sda_oe = 1'b0;
                  next_s.state = I2CRP_IDLE;
                end
              end
              I2CRP_PH_AHI: begin
                next_s.addr_hi = s.sh; // high byte first [RULE_14]
                next_s.phase = I2CRP_PH_ALO;
              end
              I2CRP_PH_ALO: begin
                // address-only write leaves this for later reads
                next_s.cur_addr = {s.addr_hi, s.sh}; // [RULE_14] [RULE_16]
                next_s.phase = I2CRP_PH_DAT;
              end
              I2CRP_PH_DAT: begin
                // whole bytes only; no count limit [RULE_15]
                next_s.req_tgl = ~s.req_tgl;
                next_s.req_we = 1'b1;
                next_s.req_addr = s.cur_addr;
                next_s.req_wdata = s.sh;
                next_s.cur_addr = s.cur_addr + 16'h0001; // [RULE_24]
              end
              default: begin
                next_s.state = I2CRP_IDLE;
                next_s.sda_oe = 1'b0;
              end
            endcase
          end
        end
        I2CRP_ACK: begin
          // ack held through the whole ninth pulse [RULE_10]
          if (scl_fall) begin
            if (s.rw == DIR_READ) begin
              // first data bit right after the address ack [RULE_17]
              next_s.state = I2CRP_TX;
              next_s.sda_oe = ~s.rd_byte[7]; // [RULE_08]
              next_s.tx = {s.rd_byte[6:0], 1'b0};
              next_s.cnt = 4'h1;
              next_s.cur_addr = s.cur_addr + 16'h0001; // [RULE_24]
            end else begin
              next_s.state = I2CRP_RX;
              next_s.sda_oe = 1'b0;
              next_s.cnt = 4'h0;
            end
          end
        end
        I2CRP_TX: begin
          // next bit set up while the clock is low [RULE_08] [RULE_09]
          if (scl_fall) begin
            if (s.cnt == BIT_LAST) begin
              next_s.sda_oe = 1'b0; // free the line for the master ack
              next_s.state = I2CRP_RACK;
              next_s.ackd = 1'b0;
            end else begin
              next_s.sda_oe = ~s.tx[7];
              next_s.tx = {s.tx[6:0], 1'b0};
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        I2CRP_RACK: begin
          if (scl_rise) begin
            // master ack: fetch the next byte during the high time
            next_s.ackd = ~sda_f; // [RULE_10] [RULE_11]
            if (!sda_f) begin
              next_s.req_tgl = ~s.req_tgl;
              next_s.req_we = 1'b0;
              next_s.req_addr = s.cur_addr;
            end
          end else if (scl_fall) begin
            if (s.ackd) begin
              next_s.state = I2CRP_TX;
              next_s.sda_oe = ~s.rd_byte[7];
              next_s.tx = {s.rd_byte[6:0], 1'b0};
              next_s.cnt = 4'h1;
              next_s.cur_addr = s.cur_addr + 16'h0001; // [RULE_24]
            end else begin
              // nack: read over, line released, wait for stop [RULE_19]
              next_s.state = I2CRP_IDLE;
              next_s.sda_oe = 1'b0;
              next_s.busy = 1'b0;
            end
          end
        end
        default: begin
          next_s.state = I2CRP_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // one register for the whole link-side state; works at any SCL rate up
  // to fast mode because every step waits for a filtered edge [RULE_01]
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      s <= '0;
      s.state <= I2CRP_IDLE;
      s.phase <= I2CRP_PH_DEV;
      s.cur_addr <= CUR_ADDR_RST;
      s.my_addr <= ADDR_BASE;
      s.scl_p <= 1'b1;
      s.sda_p <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = s.sda_oe;
  assign link_busy = s.busy;
endmodule : i2crp_top
`default_nettype wire

// file: tb/i2crp_check_sva.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_check
  import i2crp_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic link_clk, // link sampling clock
  input wire logic scl_i, // serial clock level
  input wire logic sda_o, // data drive value
  input wire logic sda_oe, // data pull-down enable
  input wire logic [15:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic reg_deny // map refusal
);
  // open drain: a driven high would fight the pull-up
  a_drive_low: assert property (
    @(posedge link_clk) disable iff (sys_rst) !sda_o)
    else $error("data line driven high");
  // the bus side only moves while the clock is low
  a_oe_rise_low: assert property (
    @(posedge link_clk) disable iff (sys_rst) $rose(sda_oe) |-> !scl_i)
    else $error("data drive started with clock high");
  a_oe_hold_high: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    (scl_i && $past(scl_i)) |-> $stable(sda_oe))
    else $error("data drive changed with clock high");
  a_ack_span: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    $rose(sda_oe) |=> sda_oe [*8])
    else $error("data drive dropped too soon");
  // refused places must never see a write strobe
  a_deny_nowr: assert property (
    @(posedge sys_clk) disable iff (sys_rst) reg_wr |-> !$past(reg_deny))
    else $error("write strobe on refused register");
  a_wr_pulse: assert property (
    @(posedge sys_clk) disable iff (sys_rst) reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  a_rd_pulse: assert property (
    @(posedge sys_clk) disable iff (sys_rst) reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");
  a_addr_settled: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_wr |-> reg_addr == $past(reg_addr))
    else $error("address moved under write strobe");
  // one request per bus byte, far slower than eight cycles
  a_byte_spacing: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*8])
    else $error("register strobes too close");
  c_write: cover property (@(posedge sys_clk) reg_wr);
  c_read: cover property (@(posedge sys_clk) reg_rd);
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule : i2crp_check
bind i2crp_top i2crp_check u_check (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_deny(reg_deny)
);
`default_nettype wire

// file: tb/i2crp_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_master #(
  parameter int Q = 625 // quarter bit time, 400 kHz
) (
  output logic scl, // clock line, stands high outside frames
  output logic sda_m, // data drive, 1 = released to pull-up
  input wire logic sda // resolved data line
);
  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start, only ever made here
  task automatic start();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask : start
  // stop after the last slot
  task automatic stop();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask : stop
  // data set while low, sampled mid-high; spike is under 50 ns
  task automatic bit_io(input logic b, input bit spike, output logic got);
    sda_m = b;
    #Q scl = 1'b1;
    #(Q / 2);
    if (spike) begin
      sda_m = ~b;
      #30 sda_m = b;
    end
    #(Q / 2) got = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_io
  // n bits msb first, ack slot only for a whole byte
  task automatic wr_byte(input logic [7:0] b, input int n, input bit spike,
                         output logic ack);
    logic g;
    g = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(b[i], spike, g);
    end
    if (n == 8) begin
      bit_io(1'b1, 1'b0, g);
    end
    ack = ~g;
  endtask : wr_byte
  // master acks wanted bytes, leaves the last one high
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 1'b0, g);
      b[i] = g;
    end
    bit_io(~ack, 1'b0, g);
  endtask : rd_byte
endmodule : i2crp_master
`default_nettype wire

// file: tb/i2crp_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2crp_bench import i2crp_pkg::*;;
  localparam logic [6:0] DEV = ADDR_BASE_DEF + 7'h3;
  logic sys_clk;
  logic link_clk;
  logic sys_rst;
  logic [2:0] addr_sel;
  logic scl;
  logic sda_m;
  wire sda;
  logic sda_o;
  logic sda_oe;
  logic reg_wr;
  logic reg_rd;
  logic link_busy;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_deny;
  logic [7:0] mem [16];
  logic a;
  logic [7:0] d;
  bit spk;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  // clocks, link side unrelated in phase
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // open-drain wire: pull-up unless the device or the master pulls low
  assign sda = sda_oe ? (sda_o & sda_m) : sda_m;
  // sixteen-byte map, everything above is refused
  assign reg_deny = reg_addr[15:4] != 12'h000;
  assign reg_rdata = mem[reg_addr[3:0]];
  always @(posedge sys_clk) begin
    if (reg_wr && !reg_deny) begin
      mem[reg_addr[3:0]] <= reg_wdata;
    end
  end
  // hang guard, the whole run needs about 90k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fails = fails + 1;
      test_done();
    end
  end
  i2crp_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_deny(reg_deny), .link_busy(link_busy));
  i2crp_master MST (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic [7:0] b, input logic exp);
    MST.wr_byte(b, 8, spk, a);
    chk("ack", {7'h0, exp}, {7'h0, a});
  endtask : wb
  task automatic rdb(input logic [7:0] exp, input logic ack);
    MST.rd_byte(d, ack);
    chk("read data", exp, d);
  endtask : rdb
  task automatic set_addr(input logic [15:0] ra);
    MST.start();
    wb({DEV, DIR_WRITE}, 1'b1);
    wb(ra[15:8], 1'b1);
    wb(ra[7:0], 1'b1);
  endtask : set_addr
  task automatic open_rd();
    MST.start();
    wb({DEV, DIR_READ}, 1'b1);
  endtask : open_rd
  // write with a short spike inside every master bit
  task automatic t_write();
    spk = 1'b1;
    set_addr(16'h0003);
    wb(8'ha5, 1'b1);
    wb(8'h3c, 1'b1);
    MST.stop();
    spk = 1'b0;
    chk("mem3", 8'ha5, mem[3]);
    chk("mem4", 8'h3c, mem[4]);
    $display("t_write done");
  endtask : t_write
  task automatic t_comb();
    set_addr(16'h0003);
    open_rd();
    rdb(8'ha5, 1'b1);
    rdb(8'h3c, 1'b0);
    MST.stop();
    chk("busy", 8'h00, {7'h0, link_busy});
    $display("t_comb done");
  endtask : t_comb
  task automatic t_cur();
    open_rd();
    rdb(8'h15, 1'b0);
    MST.stop();
    set_addr(16'h0000);
    MST.stop();
    open_rd();
    rdb(8'h10, 1'b0);
    MST.stop();
    $display("t_cur done");
  endtask : t_cur
  task automatic t_deny();
    set_addr(16'h0020);
    wb(8'h77, 1'b1);
    open_rd();
    rdb(8'h00, 1'b0);
    MST.stop();
    chk("mem0", 8'h10, mem[0]);
    $display("t_deny done");
  endtask : t_deny
  // half a byte cut off by a repeated start
  task automatic t_part();
    set_addr(16'h0001);
    MST.wr_byte(8'h00, 4, 1'b0, a);
    open_rd();
    rdb(8'h11, 1'b0);
    MST.stop();
    chk("mem1", 8'h11, mem[1]);
    $display("t_part done");
  endtask : t_part
  // strap values incl. one above the top; ends back on DEV
  task automatic t_sel();
    logic [2:0] tbl [4];
    logic [6:0] own;
    tbl = '{3'h0, 3'h6, 3'h7, 3'h3};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      addr_sel <= tbl[i];
      repeat (20) @(posedge sys_clk);
      own = ADDR_BASE_DEF + {4'h0, (tbl[i] > SEL_MAX) ? SEL_MAX : tbl[i]};
      MST.start();
      wb({own + 7'h1, DIR_WRITE}, 1'b0);
      MST.start();
      wb({own, DIR_WRITE}, 1'b1);
      MST.stop();
    end
    $display("t_sel done");
  endtask : t_sel
  initial begin
    sys_rst = 1'b1;
    addr_sel = 3'h3;
    spk = 1'b0;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'h10 + 8'(i);
    end
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (200) @(posedge sys_clk);
    t_write();
    t_comb();
    t_cur();
    t_deny();
    t_part();
    t_sel();
    test_done();
  end
endmodule : i2crp_bench
`default_nettype wire
